// [pkg/ccs_defs.svh]
// Constants for the common command and status unit.
// Assumes a 100 MHz module clock; included by the top-level design file.
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ==========================================================
// Timing
`define CCS_CLK_HZ 100000000
`define CCS_ST_TIME_S 180
`define CCS_SETTLE_TIME_S 20
`define CCS_ST_CYC (36'(`CCS_ST_TIME_S) * 36'(`CCS_CLK_HZ))
`define CCS_SETTLE_CYC (36'(`CCS_SETTLE_TIME_S) * 36'(`CCS_CLK_HZ))

// ==========================================================
// Status byte bit positions
`define CCS_SB_USER 0
`define CCS_SB_DEV 2
`define CCS_SB_QUES 3
`define CCS_SB_MAV 4
`define CCS_SB_SES 5
`define CCS_SB_MSS 6
`define CCS_SB_OPER 7

// ==========================================================
// Standard event bit positions
`define CCS_SE_OPC 0
`define CCS_SE_QRY 2
`define CCS_SE_DDE 3
`define CCS_SE_EXE 4
`define CCS_SE_CMD 5
`define CCS_SE_PON 7

// ==========================================================
// Values
`define CCS_SRE_MASK 8'hBF
`define CCS_BOUND_MIN 8'h00
`define CCS_BOUND_MAX 8'hFF
`define CCS_OPC_DONE 8'h01
`define CCS_ST_PASS 8'h00
`define CCS_ST_FAIL 8'h01

`endif

// [pkg/ccs_pkg.sv]
// Types shared by the common command and status unit.
// Assumes ccs_defs.svh is on the include path.
package ccs_pkg;

    // ==========================================================
    // Commands
    typedef enum logic [4:0] {
        CCS_CLS, CCS_ESE_W, CCS_ESE_Q, CCS_ESR_Q, CCS_IDN_Q,
        CCS_OPC_W, CCS_OPC_Q, CCS_OPT_Q, CCS_RST, CCS_SRE_W,
        CCS_SRE_Q, CCS_STB_Q, CCS_TRG, CCS_TRG_IMM, CCS_GET,
        CCS_TST_Q, CCS_WAI
    } ccs_cmd_code_t;

    typedef enum logic [1:0] {
        CCS_BND_NONE, CCS_BND_MIN, CCS_BND_MAX
    } ccs_bound_t;

    typedef struct packed {
        logic valid;
        ccs_cmd_code_t code;
        ccs_bound_t bound;
        logic [7:0] value;
    } ccs_cmd_t;

    // ==========================================================
    // Replies and status inputs
    typedef struct packed {
        logic valid;
        logic [7:0] value;
    } ccs_num_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic empty;
        logic [7:0] data;
    } ccs_txt_t;

    typedef struct packed {
        logic user_sum;
        logic dev_sum;
        logic ques_sum;
        logic mav;
        logic oper_sum;
    } ccs_sum_t;

    typedef struct packed {
        logic query_err;
        logic dev_err;
        logic exec_err;
        logic cmd_err;
    } ccs_err_t;

endpackage

// [core/ccs_event_latch.sv]
// Sticky event register: each bit latches on a rising condition.
// Assumes conditions come from logic on mclk.
`timescale 1ns/100ps
module ccs_event_latch #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [W-1:0] cond,
    input wire logic clear,
    output logic [W-1:0] ev
);
    logic [W-1:0] cond_q;
    logic [W-1:0] rise;

    if (W < 1) begin : g_bad
        $error("ccs_event_latch: W must be at least 1");
    end

    // ==========================================================
    // Per bit latch
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic next_ev;
        always_comb
        begin
            // Set wins over a read clear in the same cycle
            next_ev = (ev[i] & ~clear) | rise[i];
        end
        always_ff @(posedge mclk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                ev[i] <= 1'b0;
                cond_q[i] <= 1'b0;
            end
            else
            begin
                ev[i] <= next_ev;
                cond_q[i] <= cond[i];
            end
        end
    end

    assign rise = cond & ~cond_q;

    // ==========================================================
    // Checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_EV_HOLD:
    assert property (!clear |=> (ev & $past(ev)) == $past(ev))
        else $error("event bit dropped without clear");

    AST_EV_READ:
    assert property (clear |=> ev == $past(rise))
        else $error("event register not cleared by read");
endmodule

// [core/ccs_text_out.sv]
// Streams the identification or option reply one character a cycle.
// Assumes the caller starts a reply only when idle.
`timescale 1ns/100ps
module ccs_text_out #(
    parameter int IDN_LEN = 20,
    parameter logic [8*IDN_LEN-1:0] IDN_TEXT = "ACME,MODEL-1,A.01.00",
    parameter int OPT_LEN = 3,
    parameter logic [8*OPT_LEN-1:0] OPT_TEXT = "F24"
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic sel_idn,
    input wire logic fast_fitted,
    output logic busy,
    output ccs_pkg::ccs_txt_t txt
);
    import ccs_pkg::*;

    if (IDN_LEN < 1 || IDN_LEN > 63 || OPT_LEN < 1 || OPT_LEN > 63)
    begin : g_bad
        $error("ccs_text_out: text lengths must be 1 to 63");
    end

    logic sel;
    logic next_sel;
    logic next_busy;
    logic [5:0] idx;
    logic [5:0] next_idx;
    logic [5:0] len;
    logic [5:0] next_len;
    ccs_txt_t next_txt;

    function automatic logic [7:0] pick(input logic s, input logic [5:0] i);
        if (s)
            pick = IDN_TEXT[8*(IDN_LEN-1-int'(i)) +: 8];
        else
            pick = OPT_TEXT[8*(OPT_LEN-1-int'(i)) +: 8];
    endfunction

    // ==========================================================
    // Streaming
    always_comb
    begin
        next_sel = sel;
        next_busy = busy;
        next_idx = idx;
        next_len = len;
        next_txt = '0;
        if (go)
        begin
            next_sel = sel_idn;
            // Standard clock fitted: option reply is empty
            if (sel_idn)
                next_len = 6'(IDN_LEN);
            else
                next_len = fast_fitted ? 6'(OPT_LEN) : 6'h00;
            if (next_len == 6'h00)
            begin
                next_txt.valid = 1'b1;
                next_txt.last = 1'b1;
                next_txt.empty = 1'b1;
            end
            else
            begin
                next_txt.valid = 1'b1;
                next_txt.data = pick(sel_idn, 6'h00);
                next_txt.last = (next_len == 6'h01);
                next_busy = (next_len != 6'h01);
                next_idx = 6'h01;
            end
        end
        else if (busy)
        begin
            next_txt.valid = 1'b1;
            next_txt.data = pick(sel, idx);
            next_txt.last = (idx == len - 6'h01);
            next_busy = !next_txt.last;
            next_idx = idx + 6'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel <= 1'b0;
            busy <= 1'b0;
            idx <= 6'h00;
            len <= 6'h00;
            txt <= '0;
        end
        else
        begin
            sel <= next_sel;
            busy <= next_busy;
            idx <= next_idx;
            len <= next_len;
            txt <= next_txt;
        end
    end
endmodule

// [core/ccs_top.sv]
// Common command and status unit: enables, event latch, status byte,
// service request, trigger gating, self-test and identity replies.
// Assumes a command parser and bus engine on mclk; one strap pin.
//
// What this block does
// - Event enable mask written 0 to 255, bit n weighs two to the n.
// - Event summary is OR of set and enabled events, into status bit 5.
// - Enable query returns the mask unchanged.
// - Event register query returns its value, then clears it.
// - Event bits latch on a rising condition until read or clear.
// - Identity query returns maker, product and version, comma separated.
// - Option query returns the fast clock code, or empty on standard clock.
// - No overlapped commands; wait does nothing, complete kept for protocol.
// - Reset command restores reset state; calibration settles in 20 s.
// - Service enable ignores bit 6, which reads zero.
// - Service requested when a status bit rises with its enable set.
// - Service requested when an enable bit rises with its status set.
// - Service enable query returns the enable value.
// - Status query leaves the byte unchanged; event query and clear-status clear bit 5.
// - Status bits: user, reserved, device, questionable, queue, event, oper.
// - Bit 6 is master summary by query, request flag by poll.
// - Bus trigger acts only with bus source and waiting-for-trigger.
// - Bus trigger, immediate trigger and group execute are equivalent.
// - Self-test lasts 3 minutes, returns 0 or 1 and logs failure.
// - Clear-status empties error queue, zeroes events, keeps enables.
// - Serial poll clears the request flag, other bits untouched.
`timescale 1ns/100ps
`include "ccs_defs.svh"
module ccs_top #(
    parameter logic [35:0] ST_CYC = `CCS_ST_CYC,
    parameter logic [35:0] SETTLE_CYC = `CCS_SETTLE_CYC,
    parameter int IDN_LEN = 20,
    // Identity text value is arbitrary
    parameter logic [8*IDN_LEN-1:0] IDN_TEXT = "ACME,MODEL-1,A.01.00",
    parameter int OPT_LEN = 3,
    // Option code value is arbitrary
    parameter logic [8*OPT_LEN-1:0] FAST_CLOCK_OPTION_CODE = "F24"
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire ccs_pkg::ccs_cmd_t cmd,
    input wire logic poll_req,
    input wire ccs_pkg::ccs_sum_t sums,
    input wire ccs_pkg::ccs_err_t errs,
    input wire logic wait_trig,
    input wire logic trig_src_bus,
    input wire logic st_fail,
    input wire logic fast_clock_fitted,
    output logic cmd_ready,
    output ccs_pkg::ccs_num_t num_rsp,
    output ccs_pkg::ccs_num_t poll_rsp,
    output ccs_pkg::ccs_txt_t txt_rsp,
    output logic srq,
    output logic trig_pulse,
    output logic clr_pulse,
    output logic err_push,
    output logic soft_rst,
    output logic cal_settled
);
    import ccs_pkg::*;

    if (ST_CYC == 36'h0 || SETTLE_CYC == 36'h0)
    begin : g_bad
        $error("ccs_top: cycle counts must be nonzero");
    end

    // ==========================================================
    // State
    logic [7:0] ese;
    logic [7:0] sre;
    logic [7:0] sre_q;
    logic [7:0] stb_q;
    logic pon;
    logic st_run;
    logic [35:0] st_cnt;
    logic [35:0] set_cnt;
    logic [2:0] fck_sh;
    logic fck_st;
    logic [7:0] esr;
    logic txt_busy;

    logic [7:0] next_ese;
    logic [7:0] next_sre;
    logic next_srq;
    logic next_pon;
    logic next_st_run;
    logic [35:0] next_st_cnt;
    logic [35:0] next_set_cnt;
    logic next_settled;
    logic next_ready;
    logic next_trig;
    logic next_clr;
    logic next_err;
    logic next_srst;
    logic [2:0] next_fck_sh;
    logic next_fck_st;
    ccs_num_t next_num;
    ccs_num_t next_poll;

    // ==========================================================
    // Decode
    logic take;
    logic [7:0] wval;
    logic esr_clr;
    logic txt_go;
    logic is_trg;
    logic [7:0] se_cond;
    logic ses_now;
    logic mss;
    logic req;
    logic [7:0] stb_now;
    logic [7:0] sb_query;
    logic [7:0] sb_poll;

    always_comb
    begin
        take = cmd.valid && cmd_ready;
        unique case (cmd.bound)
            CCS_BND_MIN: wval = `CCS_BOUND_MIN;
            CCS_BND_MAX: wval = `CCS_BOUND_MAX;
            default: wval = cmd.value;
        endcase
        esr_clr = take && (cmd.code == CCS_ESR_Q || cmd.code == CCS_CLS);
        txt_go = take && (cmd.code == CCS_IDN_Q || cmd.code == CCS_OPT_Q);
        is_trg = cmd.code == CCS_TRG || cmd.code == CCS_TRG_IMM
            || cmd.code == CCS_GET;
        se_cond = 8'h00;
        // Operation complete event: nothing is ever pending
        se_cond[`CCS_SE_OPC] = take && cmd.code == CCS_OPC_W;
        se_cond[`CCS_SE_QRY] = errs.query_err;
        se_cond[`CCS_SE_DDE] = errs.dev_err;
        se_cond[`CCS_SE_EXE] = errs.exec_err;
        se_cond[`CCS_SE_CMD] = errs.cmd_err;
        se_cond[`CCS_SE_PON] = pon;
        ses_now = |(esr & ese);
        stb_now = 8'h00;
        stb_now[`CCS_SB_USER] = sums.user_sum;
        stb_now[`CCS_SB_DEV] = sums.dev_sum;
        stb_now[`CCS_SB_QUES] = sums.ques_sum;
        stb_now[`CCS_SB_MAV] = sums.mav;
        stb_now[`CCS_SB_SES] = ses_now;
        stb_now[`CCS_SB_OPER] = sums.oper_sum;
        mss = |(stb_now & sre);
        sb_query = stb_now;
        sb_query[`CCS_SB_MSS] = mss;
        sb_poll = stb_now;
        sb_poll[`CCS_SB_MSS] = srq;
        req = |(((stb_now & ~stb_q) & sre)
            | ((sre & ~sre_q) & stb_now));
    end

    ccs_event_latch #(
        .W(8)
    ) u_latch (
        .mclk(mclk),
        .rst_b(rst_b),
        .cond(se_cond),
        .clear(esr_clr),
        .ev(esr)
    );

    ccs_text_out #(
        .IDN_LEN(IDN_LEN),
        .IDN_TEXT(IDN_TEXT),
        .OPT_LEN(OPT_LEN),
        .OPT_TEXT(FAST_CLOCK_OPTION_CODE)
    ) u_text (
        .mclk(mclk),
        .rst_b(rst_b),
        .go(txt_go),
        .sel_idn(cmd.code == CCS_IDN_Q),
        .fast_fitted(fck_st),
        .busy(txt_busy),
        .txt(txt_rsp)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        next_ese = ese;
        next_sre = sre;
        // A pending request holds until polled; a new one beats the poll
        next_srq = (srq & ~poll_req) | req;
        next_pon = 1'b0;
        next_st_run = st_run;
        next_st_cnt = st_cnt;
        next_set_cnt = set_cnt;
        next_settled = cal_settled;
        next_trig = 1'b0;
        next_clr = 1'b0;
        next_err = 1'b0;
        next_srst = 1'b0;
        next_num = '0;
        next_poll = '0;
        // Strap: first stage feeds only the second
        next_fck_sh = {fck_sh[1:0], fast_clock_fitted};
        next_fck_st = (fck_sh[1] == fck_sh[2]) ? fck_sh[2] : fck_st;
        if (poll_req)
            next_poll = '{valid: 1'b1, value: sb_poll};
        if (!cal_settled)
        begin
            next_set_cnt = set_cnt + 36'h1;
            next_settled = (set_cnt == SETTLE_CYC - 36'h1);
        end
        if (st_run)
        begin
            next_st_cnt = st_cnt + 36'h1;
            if (st_cnt == ST_CYC - 36'h1)
            begin
                next_st_run = 1'b0;
                next_num.valid = 1'b1;
                next_num.value = st_fail ? `CCS_ST_FAIL : `CCS_ST_PASS;
                next_err = st_fail;
            end
        end
        if (take)
        begin
            unique case (cmd.code)
                CCS_CLS: next_clr = 1'b1;
                CCS_ESE_W: next_ese = wval;
                CCS_ESE_Q: next_num = '{valid: 1'b1, value: ese};
                CCS_ESR_Q: next_num = '{valid: 1'b1, value: esr};
                CCS_OPC_Q:
                    next_num = '{valid: 1'b1, value: `CCS_OPC_DONE};
                CCS_SRE_W: next_sre = wval & `CCS_SRE_MASK;
                CCS_SRE_Q: next_num = '{valid: 1'b1, value: sre};
                CCS_STB_Q: next_num = '{valid: 1'b1, value: sb_query};
                CCS_RST:
                begin
                    next_srst = 1'b1;
                    next_set_cnt = 36'h0;
                    next_settled = 1'b0;
                end
                CCS_TRG, CCS_TRG_IMM, CCS_GET:
                    next_trig = trig_src_bus && wait_trig;
                CCS_TST_Q:
                begin
                    next_st_run = 1'b1;
                    next_st_cnt = 36'h0;
                end
                CCS_IDN_Q, CCS_OPT_Q, CCS_OPC_W, CCS_WAI: ;
                default: ;
            endcase
        end
        // Hold off commands while a reply is still being produced
        next_ready = !next_st_run && !txt_go && !txt_busy;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ese <= 8'h00;
            sre <= 8'h00;
            sre_q <= 8'h00;
            stb_q <= 8'h00;
            srq <= 1'b0;
            pon <= 1'b1;
            st_run <= 1'b0;
            st_cnt <= 36'h0;
            set_cnt <= 36'h0;
            cal_settled <= 1'b0;
            cmd_ready <= 1'b0;
            trig_pulse <= 1'b0;
            clr_pulse <= 1'b0;
            err_push <= 1'b0;
            soft_rst <= 1'b0;
            num_rsp <= '0;
            poll_rsp <= '0;
            fck_sh <= 3'h0;
            fck_st <= 1'b0;
        end
        else
        begin
            ese <= next_ese;
            sre <= next_sre;
            sre_q <= sre;
            stb_q <= stb_now;
            srq <= next_srq;
            pon <= next_pon;
            st_run <= next_st_run;
            st_cnt <= next_st_cnt;
            set_cnt <= next_set_cnt;
            cal_settled <= next_settled;
            cmd_ready <= next_ready;
            trig_pulse <= next_trig;
            clr_pulse <= next_clr;
            err_push <= next_err;
            soft_rst <= next_srst;
            num_rsp <= next_num;
            poll_rsp <= next_poll;
            fck_sh <= next_fck_sh;
            fck_st <= next_fck_st;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_ESE_STORE:
    assert property (take && cmd.code == CCS_ESE_W |=> ese == $past(wval))
        else $error("event enable not stored");

    AST_SES_BIT:
    assert property (take && cmd.code == CCS_STB_Q
        |=> num_rsp.valid && num_rsp.value[`CCS_SB_SES] == $past(ses_now))
        else $error("event summary wrong in status byte");

    AST_ESE_QUERY:
    assert property (take && cmd.code == CCS_ESE_Q
        |=> num_rsp.value == $past(ese) && ese == $past(ese))
        else $error("enable query wrong");

    AST_SRE_MASK:
    assert property (take && cmd.code == CCS_SRE_W
        |=> sre == ($past(wval) & `CCS_SRE_MASK) && !sre[`CCS_SB_MSS])
        else $error("service enable bit 6 not ignored");

    AST_SRQ_RISE:
    assert property (|(stb_now & ~stb_q & sre) |=> srq)
        else $error("no request on status rise");

    AST_SRQ_ENA:
    assert property (|(sre & ~sre_q & stb_now) |=> srq)
        else $error("no request on enable rise");

    AST_POLL:
    assert property (poll_req && !req
        |=> !srq && poll_rsp.valid
        && poll_rsp.value[`CCS_SB_MSS] == $past(srq))
        else $error("serial poll did not clear request");

    AST_MSS:
    assert property (take && cmd.code == CCS_STB_Q
        |=> num_rsp.value[`CCS_SB_MSS] == $past(mss)
        && (!$past(srq) || $past(poll_req) || srq))
        else $error("master summary wrong");

    AST_TRG_GATE:
    assert property (take && is_trg && !(trig_src_bus && wait_trig)
        |=> !trig_pulse)
        else $error("trigger not ignored");

    AST_CLS:
    assert property (take && cmd.code == CCS_CLS
        |=> clr_pulse && ese == $past(ese) && sre == $past(sre)
        && (esr & ~$past(se_cond)) == 8'h00)
        else $error("clear-status wrong");
endmodule

// [verif/ccs_ctl_model.sv]
// Bus controller model: issues commands, serial polls, settle waits.
// Assumes ccs_top on the same mclk; drives on the falling edge.
`timescale 1ns/100ps
module ccs_ctl_model
(
    input wire logic mclk,
    input wire logic cmd_ready,
    input wire logic cal_settled,
    output ccs_pkg::ccs_cmd_t cmd,
    output logic poll_req
);
    import ccs_pkg::*;

    initial
    begin
        cmd = '0;
        poll_req = 1'b0;
    end

    // ==========================================================
    // Command, held until taken; value lines inverted once released
    task automatic send(input ccs_cmd_code_t c, input ccs_bound_t b,
        input logic [7:0] v);
    begin
        @(negedge mclk);
        cmd = {1'b1, c, b, v};
        while (cmd_ready !== 1'b1)
            @(negedge mclk);
        @(negedge mclk);
        cmd.valid = 1'b0;
        cmd.value = ~v;
    end
    endtask

    task automatic poll();
    begin
        @(negedge mclk);
        poll_req = 1'b1;
        @(negedge mclk);
        poll_req = 1'b0;
    end
    endtask

    // ==========================================================
    // Calibration is not trusted before the settle flag rises
    task automatic settle(input int n);
        int k;
    begin
        for (k = 0; k < n && cal_settled !== 1'b1; k++)
            @(negedge mclk);
    end
    endtask
endmodule

// [verif/common_command_status_unit_tb.sv]
// Testbench for the common command and status unit.
// Assumes ccs_top with shortened self-test and settle counts.
`timescale 1ns/100ps
module common_command_status_unit_tb;
    import ccs_pkg::*;

    localparam logic [159:0] IDN = "ACME,MODEL-1,A.01.00";
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic wait_trig = 1'b0;
    logic trig_src_bus = 1'b0;
    logic st_fail = 1'b0;
    logic fast_fit = 1'b0;
    ccs_sum_t sums = '0;
    ccs_err_t errs = '0;
    ccs_cmd_t cmd;
    ccs_num_t num_rsp;
    ccs_num_t poll_rsp;
    ccs_txt_t txt_rsp;
    logic poll_req, cmd_ready, srq, trig_pulse, clr_pulse, err_push;
    logic soft_rst, cal_settled;
    int err_count = 0;
    int samples_checked = 0;
    int pos[5] = '{0, 2, 3, 4, 7};
    ccs_cmd_code_t tc[3] = '{CCS_TRG, CCS_TRG_IMM, CCS_GET};

    always #5 mclk = ~mclk;

    ccs_top #(.ST_CYC(36'd20), .SETTLE_CYC(36'd30), .IDN_TEXT(IDN)) i_dut
    (
        .mclk(mclk), .rst_b(rst_b), .cmd(cmd), .poll_req(poll_req),
        .sums(sums), .errs(errs), .wait_trig(wait_trig),
        .trig_src_bus(trig_src_bus), .st_fail(st_fail),
        .fast_clock_fitted(fast_fit), .cmd_ready(cmd_ready),
        .num_rsp(num_rsp), .poll_rsp(poll_rsp), .txt_rsp(txt_rsp),
        .srq(srq), .trig_pulse(trig_pulse), .clr_pulse(clr_pulse),
        .err_push(err_push), .soft_rst(soft_rst),
        .cal_settled(cal_settled)
    );

    ccs_ctl_model i_ctl
    (
        .mclk(mclk), .cmd_ready(cmd_ready), .cal_settled(cal_settled),
        .cmd(cmd), .poll_req(poll_req)
    );

    // ==========================================================
    // Helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask

    task automatic q(input ccs_cmd_code_t c, input logic [7:0] exp);
    begin
        i_ctl.send(c, CCS_BND_NONE, 8'h00);
        chk(8'(num_rsp.valid), 8'h01);
        chk(num_rsp.value, exp);
    end
    endtask

    task automatic w(input ccs_cmd_code_t c, input ccs_bound_t b,
        input logic [7:0] v);
    begin
        i_ctl.send(c, b, v);
        @(negedge mclk);
    end
    endtask

    task automatic rd_txt(input ccs_cmd_code_t c, input logic [159:0] t,
        input int n);
        int k;
    begin
        i_ctl.send(c, CCS_BND_NONE, 8'h00);
        for (k = n - 1; k >= 0; k--)
        begin
            chk(txt_rsp.data, t[8*k +: 8]);
            chk(8'({txt_rsp.valid, txt_rsp.last}), 8'(2 + (k == 0)));
            if (k > 0)
                @(negedge mclk);
        end
    end
    endtask

    task automatic stop_test();
    begin
        $display("Checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    // Whole sequence needs well under a thousand cycles
    initial
    begin
        #50000;
        err_count++;
        stop_test();
    end

    // ==========================================================
    // Tests
    initial
    begin
        int i;
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        q(CCS_ESE_Q, 8'h00);
        q(CCS_SRE_Q, 8'h00);
        q(CCS_ESR_Q, 8'h80);
        q(CCS_ESR_Q, 8'h00);
        w(CCS_ESE_W, CCS_BND_NONE, 8'h65);
        q(CCS_ESE_Q, 8'h65);
        w(CCS_ESE_W, CCS_BND_MAX, 8'h12);
        q(CCS_ESE_Q, 8'hFF);
        w(CCS_ESE_W, CCS_BND_MIN, 8'h12);
        q(CCS_ESE_Q, 8'h00);
        $display("Test enables done");
        for (i = 0; i < 5; i++)
        begin
            sums = ccs_sum_t'(5'b10000 >> i);
            @(negedge mclk);
            q(CCS_STB_Q, 8'h01 << pos[i]);
        end
        sums.mav = 1'b1;
        repeat (2) @(negedge mclk);
        chk(8'(srq), 8'h00);
        w(CCS_SRE_W, CCS_BND_NONE, 8'hFF);
        @(negedge mclk);
        chk(8'(srq), 8'h01);
        q(CCS_SRE_Q, 8'hBF);
        i_ctl.poll();
        chk(8'(poll_rsp.valid), 8'h01);
        chk(poll_rsp.value, 8'hD0);
        @(negedge mclk);
        chk(8'(srq), 8'h00);
        q(CCS_STB_Q, 8'hD0);
        sums = '0;
        $display("Test status byte done");
        w(CCS_ESE_W, CCS_BND_NONE, 8'h20);
        errs.cmd_err = 1'b1;
        repeat (3) @(negedge mclk);
        chk(8'(srq), 8'h01);
        q(CCS_STB_Q, 8'h60);
        errs = '0;
        q(CCS_ESR_Q, 8'h20);
        q(CCS_STB_Q, 8'h00);
        i_ctl.poll();
        errs.cmd_err = 1'b1;
        repeat (2) @(negedge mclk);
        errs = '0;
        i_ctl.send(CCS_CLS, CCS_BND_NONE, 8'h00);
        chk(8'(clr_pulse), 8'h01);
        q(CCS_ESR_Q, 8'h00);
        q(CCS_ESE_Q, 8'h20);
        q(CCS_SRE_Q, 8'hBF);
        w(CCS_WAI, CCS_BND_NONE, 8'h00);
        w(CCS_OPC_W, CCS_BND_NONE, 8'h00);
        q(CCS_OPC_Q, 8'h01);
        q(CCS_ESR_Q, 8'h01);
        $display("Test events done");
        for (i = 0; i < 12; i++)
        begin
            trig_src_bus = i[0];
            wait_trig = i[1];
            i_ctl.send(tc[i/4], CCS_BND_NONE, 8'h00);
            chk(8'(trig_pulse), 8'(i[0] & i[1]));
        end
        $display("Test triggers done");
        rd_txt(CCS_IDN_Q, IDN, 20);
        i_ctl.send(CCS_OPT_Q, CCS_BND_NONE, 8'h00);
        chk(8'({txt_rsp.valid, txt_rsp.last, txt_rsp.empty}), 8'h07);
        fast_fit = 1'b1;
        repeat (5) @(negedge mclk);
        rd_txt(CCS_OPT_Q, "F24", 3);
        $display("Test text done");
        for (i = 0; i < 2; i++)
        begin
            st_fail = i[0];
            i_ctl.send(CCS_TST_Q, CCS_BND_NONE, 8'h00);
            chk(8'(cmd_ready), 8'h00);
            while (num_rsp.valid !== 1'b1)
                @(negedge mclk);
            chk(8'({num_rsp.valid, err_push}), 8'(2 + i));
            chk(num_rsp.value, 8'(i));
        end
        $display("Test self-test done");
        i_ctl.send(CCS_RST, CCS_BND_NONE, 8'h00);
        chk(8'({soft_rst, cal_settled}), 8'h02);
        i_ctl.settle(40);
        chk(8'(cal_settled), 8'h01);
        $display("Test reset done");
        stop_test();
    end
endmodule
